// ---- logic/ppc_top.v ----
// port pin config block: ahb-lite register file, edge interrupts and port r pads
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ppc_regs.vh"
module ppc_top #(
  parameter W = 8
) (
  input wire mclk,
  input wire nrst,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [W-1:0] r_dir_out,
  input wire [W-1:0] r_out_data,
  input wire [W-1:0] r_pad_i,
  output wire [W-1:0] r_pad_o,
  output wire [W-1:0] r_pad_oe_n,
  output wire [W-1:0] r_pull_up_en,
  output wire [W-1:0] r_pull_dn_en,
  input wire [W-1:0] t_pin_i,
  input wire [W-1:0] s_pin_i,
  output reg irq_r,
  output reg irq_t,
  output reg irq_s
);
  // register storage
  reg [7:0] r_pol_reg;
  reg [7:0] r_od_reg;
  reg [7:0] r_pe_reg;
  reg [7:0] t_pol_reg;
  reg [7:0] t_ie_reg;
  reg [7:0] t_if_reg;
  reg [7:0] s_pol_reg;
  reg [7:0] s_ie_reg;
  reg [7:0] s_if_reg;
  reg [7:0] r_ie_reg;
  reg [7:0] r_if_reg;
  reg [7:0] t_if_next;
  reg [7:0] s_if_next;
  reg [7:0] r_if_next;
  reg [7:0] r_pol_next;
  reg [7:0] r_od_next;
  reg [7:0] r_pe_next;
  reg [7:0] t_pol_next;
  reg [7:0] t_ie_next;
  reg [7:0] s_pol_next;
  reg [7:0] s_ie_next;
  reg [7:0] r_ie_next;

  // data phase bookkeeping
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [31:0] rdata_next;

  wire addr_phase;
  wire rd_take;
  wire [7:0] wdata;
  wire [7:0] wr_mask_t;
  wire [7:0] wr_mask_s;
  wire [7:0] wr_mask_r;
  wire [W-1:0] r_edge;
  wire [W-1:0] t_edge;
  wire [W-1:0] s_edge;
  wire [W-1:0] r_sync;
  wire [W-1:0] t_sync;
  wire [W-1:0] s_sync;
  wire [7:0] pin_r8;
  wire [7:0] pin_t8;
  wire [7:0] pin_s8;
  wire [7:0] edge_r8;
  wire [7:0] edge_t8;
  wire [7:0] edge_s8;

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = `PPC_HRESP_OKAY;

  assign addr_phase = hsel & hready & (htrans == `PPC_HTRANS_NONSEQ);
  assign rd_take = addr_phase & ~hwrite;
  assign wdata = hwdata[7:0];

  // pins of the three ports
  ppc_edge_det #(
    .W(W)
  ) u_edge_r (
    .mclk(mclk),
    .nrst(nrst),
    .pin_i(r_pad_i),
    .rise_sel(r_pol_reg[W-1:0]),
    .edge_hit(r_edge),
    .pin_sync(r_sync)
  );

  ppc_edge_det #(
    .W(W)
  ) u_edge_t (
    .mclk(mclk),
    .nrst(nrst),
    .pin_i(t_pin_i),
    .rise_sel(t_pol_reg[W-1:0]),
    .edge_hit(t_edge),
    .pin_sync(t_sync)
  );

  ppc_edge_det #(
    .W(W)
  ) u_edge_s (
    .mclk(mclk),
    .nrst(nrst),
    .pin_i(s_pin_i),
    .rise_sel(s_pol_reg[W-1:0]),
    .edge_hit(s_edge),
    .pin_sync(s_sync)
  );

  ppc_pad_ctrl #(
    .W(W)
  ) u_pad_r (
    .mclk(mclk),
    .nrst(nrst),
    .dir_out(r_dir_out),
    .out_data(r_out_data),
    .open_drain(r_od_reg[W-1:0]),
    .pull_en(r_pe_reg[W-1:0]),
    .pull_pol(r_pol_reg[W-1:0]),
    .pad_o(r_pad_o),
    .pad_oe_n(r_pad_oe_n),
    .pull_up_en(r_pull_up_en),
    .pull_dn_en(r_pull_dn_en)
  );

  assign pin_r8 = r_sync[7:0];
  assign pin_t8 = t_sync[7:0];
  assign pin_s8 = s_sync[7:0];
  assign edge_r8 = r_edge[7:0];
  assign edge_t8 = t_edge[7:0];
  assign edge_s8 = s_edge[7:0];

  // address phase capture for writes
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= addr_phase & hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // w1c masks, only in the write data phase
  assign wr_mask_t = (wr_pend_reg && wr_addr_reg == `PPC_T_IF_OFS) ? wdata : 8'h00;
  assign wr_mask_s = (wr_pend_reg && wr_addr_reg == `PPC_S_IF_OFS) ? wdata : 8'h00;
  assign wr_mask_r = (wr_pend_reg && wr_addr_reg == `PPC_R_IF_OFS) ? wdata : 8'h00;

  // flag update: edge set applied after the clear, so it wins
  always @* begin
    t_if_next = ((t_if_reg & ~wr_mask_t) | edge_t8) & `PPC_T_MASK;
    s_if_next = ((s_if_reg & ~wr_mask_s) | edge_s8) & `PPC_S_MASK;
    r_if_next = ((r_if_reg & ~wr_mask_r) | edge_r8) & `PPC_R_IRQ_MASK;
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      t_if_reg <= `PPC_IF_RST;
      s_if_reg <= `PPC_IF_RST;
      r_if_reg <= `PPC_IF_RST;
    end else begin
      t_if_reg <= t_if_next;
      s_if_reg <= s_if_next;
      r_if_reg <= r_if_next;
    end
  end

  // plain read/write registers; reserved and unmapped writes drop
  always @* begin
    r_pol_next = r_pol_reg;
    r_od_next = r_od_reg;
    r_pe_next = r_pe_reg;
    t_pol_next = t_pol_reg;
    t_ie_next = t_ie_reg;
    s_pol_next = s_pol_reg;
    s_ie_next = s_ie_reg;
    r_ie_next = r_ie_reg;
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        `PPC_R_POL_OFS: begin
          r_pol_next = wdata;
        end
        `PPC_R_OD_OFS: begin
          r_od_next = wdata;
        end
        `PPC_R_PE_OFS: begin
          r_pe_next = wdata;
        end
        `PPC_T_POL_OFS: begin
          t_pol_next = wdata & `PPC_T_MASK;
        end
        `PPC_T_IE_OFS: begin
          t_ie_next = wdata & `PPC_T_MASK;
        end
        `PPC_S_POL_OFS: begin
          s_pol_next = wdata & `PPC_S_MASK;
        end
        `PPC_S_IE_OFS: begin
          s_ie_next = wdata & `PPC_S_MASK;
        end
        `PPC_R_IE_OFS: begin
          r_ie_next = wdata & `PPC_R_IRQ_MASK;
        end
        default: begin
          r_pol_next = r_pol_reg;
        end
      endcase
    end
  end

  // register storage update
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_pol_reg <= `PPC_POL_RST;
      r_od_reg <= `PPC_OD_RST;
      r_pe_reg <= `PPC_PE_RST;
      t_pol_reg <= `PPC_POL_RST;
      t_ie_reg <= `PPC_IE_RST;
      s_pol_reg <= `PPC_POL_RST;
      s_ie_reg <= `PPC_IE_RST;
      r_ie_reg <= `PPC_IE_RST;
    end else begin
      r_pol_reg <= r_pol_next;
      r_od_reg <= r_od_next;
      r_pe_reg <= r_pe_next;
      t_pol_reg <= t_pol_next;
      t_ie_reg <= t_ie_next;
      s_pol_reg <= s_pol_next;
      s_ie_reg <= s_ie_next;
      r_ie_reg <= r_ie_next;
    end
  end

  // read mux, sampled in the address phase; a read right behind a write sees the new value
  always @* begin
    rdata_next = 32'h0000_0000;
    case (haddr)
      `PPC_R_POL_OFS: begin
        rdata_next[7:0] = r_pol_next;
      end
      `PPC_R_OD_OFS: begin
        rdata_next[7:0] = r_od_next;
      end
      `PPC_R_PE_OFS: begin
        rdata_next[7:0] = r_pe_next;
      end
      `PPC_T_POL_OFS: begin
        rdata_next[7:0] = t_pol_next;
      end
      `PPC_T_IE_OFS: begin
        rdata_next[7:0] = t_ie_next;
      end
      `PPC_T_IF_OFS: begin
        rdata_next[7:0] = t_if_next;
      end
      `PPC_S_POL_OFS: begin
        rdata_next[7:0] = s_pol_next;
      end
      `PPC_S_IE_OFS: begin
        rdata_next[7:0] = s_ie_next;
      end
      `PPC_S_IF_OFS: begin
        rdata_next[7:0] = s_if_next;
      end
      `PPC_R_IE_OFS: begin
        rdata_next[7:0] = r_ie_next;
      end
      `PPC_R_IF_OFS: begin
        rdata_next[7:0] = r_if_next;
      end
      `PPC_PIN_OFS: begin
        rdata_next[`PPC_PIN_R_LSB+7:`PPC_PIN_R_LSB] = pin_r8;
        rdata_next[`PPC_PIN_T_LSB+7:`PPC_PIN_T_LSB] = pin_t8;
        rdata_next[`PPC_PIN_S_LSB+7:`PPC_PIN_S_LSB] = pin_s8;
      end
      default: begin
        rdata_next[7:0] = `PPC_RSV_VAL;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rdata_next;
    end
  end

  // per-port requests from flags and enables
  wire [7:0] r_pend;
  wire [7:0] t_pend;
  wire [7:0] s_pend;
  assign r_pend = r_if_reg & r_ie_reg;
  assign t_pend = t_if_reg & t_ie_reg;
  assign s_pend = s_if_reg & s_ie_reg;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
      irq_t <= 1'b0;
      irq_s <= 1'b0;
    end else begin
      irq_r <= |r_pend;
      irq_t <= |t_pend;
      irq_s <= |s_pend;
    end
  end

  // hsize is not decoded: only whole-word transfers reach this slave
  wire unused_hsize;
  assign unused_hsize = ^hsize;
endmodule

// ---- logic/ppc_regs.vh ----
// register offsets, field masks, reset values and timing for the port pin config block
`ifndef PPC_REGS_VH
`define PPC_REGS_VH

// byte addresses of the registers
`define PPC_R_POL_OFS 8'h00
`define PPC_R_OD_OFS 8'h04
`define PPC_R_PE_OFS 8'h08
`define PPC_T_POL_OFS 8'h0c
`define PPC_T_IE_OFS 8'h10
`define PPC_T_IF_OFS 8'h14
`define PPC_S_POL_OFS 8'h18
`define PPC_S_IE_OFS 8'h1c
`define PPC_S_IF_OFS 8'h20
`define PPC_R_IE_OFS 8'h24
`define PPC_R_IF_OFS 8'h28
`define PPC_PIN_OFS 8'h2c

// reserved block: first and last word
`define PPC_RSV_LO 8'h30
`define PPC_RSV_HI 8'h3c

// implemented bits per register
`define PPC_T_MASK 8'h60
`define PPC_S_MASK 8'h6c
`define PPC_R_IRQ_MASK 8'h1f
`define PPC_R_MASK 8'hff

// reset values
`define PPC_POL_RST 8'h00
`define PPC_OD_RST 8'h00
`define PPC_PE_RST 8'hff
`define PPC_IE_RST 8'h00
`define PPC_IF_RST 8'h00
`define PPC_RSV_VAL 8'h00

// bit positions of the pin snapshot register
`define PPC_PIN_R_LSB 0
`define PPC_PIN_T_LSB 8
`define PPC_PIN_S_LSB 16

// synchroniser fill time before edges count
`define PPC_ARM_CYCLES 2'd3

// htrans and hresp encodings
`define PPC_HTRANS_NONSEQ 2'h2
`define PPC_HRESP_OKAY 1'b0

`endif

// ---- logic/ppc_edge_det.v ----
// pin synchroniser and polarity-selected edge detector, one lane per pin
`timescale 1ns/1ps
`include "ppc_regs.vh"
module ppc_edge_det #(
  parameter W = 8
) (
  input wire mclk,
  input wire nrst,
  input wire [W-1:0] pin_i,
  input wire [W-1:0] rise_sel,
  output wire [W-1:0] edge_hit,
  output wire [W-1:0] pin_sync
);
  reg [1:0] arm_reg;
  wire armed;
  assign armed = (arm_reg == `PPC_ARM_CYCLES);

  // no edge counts until the synchroniser chain holds real pin levels
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arm_reg <= 2'd0;
    end else if (!armed) begin
      arm_reg <= arm_reg + 2'd1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      reg meta_reg;
      reg sync_reg;
      reg prev_reg;
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          prev_reg <= 1'b0;
        end else begin
          meta_reg <= pin_i[i];
          sync_reg <= meta_reg;
          prev_reg <= sync_reg;
        end
      end
      // rising when selected, falling otherwise
      assign edge_hit[i] = armed & (rise_sel[i] ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg));
      assign pin_sync[i] = sync_reg;
    end
  endgenerate
endmodule

// ---- logic/ppc_pad_ctrl.v ----
// port r pad control: drive enable, open-drain and pull device selection
`timescale 1ns/1ps
module ppc_pad_ctrl #(
  parameter W = 8
) (
  input wire mclk,
  input wire nrst,
  input wire [W-1:0] dir_out,
  input wire [W-1:0] out_data,
  input wire [W-1:0] open_drain,
  input wire [W-1:0] pull_en,
  input wire [W-1:0] pull_pol,
  output reg [W-1:0] pad_o,
  output reg [W-1:0] pad_oe_n,
  output reg [W-1:0] pull_up_en,
  output reg [W-1:0] pull_dn_en
);
  wire [W-1:0] drive;
  wire [W-1:0] is_in;
  assign is_in = ~dir_out;
  // open-drain lanes only drive when the data is low
  assign drive = dir_out & ~(open_drain & out_data);

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pad_o <= {W{1'b0}};
      pad_oe_n <= {W{1'b1}};
      pull_up_en <= {W{1'b0}};
      pull_dn_en <= {W{1'b0}};
    end else begin
      pad_o <= out_data & ~open_drain;
      pad_oe_n <= ~drive;
      pull_up_en <= is_in & pull_en & ~pull_pol;
      pull_dn_en <= is_in & pull_en & pull_pol;
    end
  end
endmodule

// ---- tb/ppc_pins_model.sv ----
// far-side devices on ports r, t and s
`timescale 1ns/1ps
module ppc_pins_model (
  input wire mclk,
  input wire [7:0] r_pad_o,
  input wire [7:0] r_pad_oe_n,
  input wire [7:0] r_pull_up_en,
  output logic [7:0] r_pad_i,
  output logic [7:0] t_pin_i,
  output logic [7:0] s_pin_i
);
  logic [7:0] r_ext = 8'h1e;
  logic [7:0] r_ext_en = 8'hff;
  initial begin
    t_pin_i = 8'h00;
    s_pin_i = 8'h6c;
  end
  // device drive wins, then the far driver, then a pull-up, else low
  always_comb r_pad_i = ~r_pad_oe_n & r_pad_o | r_pad_oe_n & (r_ext_en & r_ext | ~r_ext_en & r_pull_up_en);
  task drive(input logic [1:0] p, input logic [7:0] v);
    @(posedge mclk);
    case (p)
      2'd0: r_ext <= v;
      2'd1: t_pin_i <= v;
      2'd2: s_pin_i <= v;
      default: r_ext_en <= v;
    endcase
  endtask
endmodule

// ---- tb/ppc_top_asserts.sv ----
// port-level assertions for the port pin config block
`timescale 1ns/1ps
module ppc_top_asserts #(
  parameter W = 8
) (
  input wire mclk,
  input wire nrst,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [W-1:0] r_dir_out,
  input wire [W-1:0] r_out_data,
  input wire [W-1:0] r_pad_i,
  input wire [W-1:0] r_pad_o,
  input wire [W-1:0] r_pad_oe_n,
  input wire [W-1:0] r_pull_up_en,
  input wire [W-1:0] r_pull_dn_en,
  input wire [W-1:0] t_pin_i,
  input wire [W-1:0] s_pin_i,
  input wire irq_r,
  input wire irq_t,
  input wire irq_s
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence rd_take;
    hsel && hready && htrans == 2'h2 && !hwrite;
  endsequence
  sequence rsv_take;
    rd_take ##0 (haddr >= 8'h30 && haddr <= 8'h3f);
  endsequence
  sequence quiet;
    $stable({t_pin_i, s_pin_i, r_pad_i}) && !(hsel && hwrite && htrans == 2'h2);
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or not okay");
  chk_rsv_zero: assert property (rsv_take |=> hrdata == 32'h0)
    else $error("reserved read not zero");
  chk_rd_hold: assert property (!(hsel && hready && htrans == 2'h2 && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_upper_zero: assert property (hrdata[31:24] == 8'h0)
    else $error("read data top byte set");
  chk_in_undriven: assert property (&(r_pad_oe_n | $past(r_dir_out)))
    else $error("input pin driven");
  chk_od_nohigh: assert property ((r_pad_o & ~r_pad_oe_n & ~$past(r_out_data)) == 0)
    else $error("pad driven high without data");
  chk_pull_input: assert property (((r_pull_up_en | r_pull_dn_en) & $past(r_dir_out)) == 0)
    else $error("pull on output pin");
  chk_pull_excl: assert property ((r_pull_up_en & r_pull_dn_en) == 0)
    else $error("both pulls on");
  chk_irq_quiet: assert property (quiet [*6] |=> !($rose(irq_r) || $rose(irq_t) || $rose(irq_s)))
    else $error("interrupt without cause");
endmodule
bind ppc_top ppc_top_asserts #(
  .W(W)
) u_chk (
  .mclk(mclk),
  .nrst(nrst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .r_dir_out(r_dir_out),
  .r_out_data(r_out_data),
  .r_pad_i(r_pad_i),
  .r_pad_o(r_pad_o),
  .r_pad_oe_n(r_pad_oe_n),
  .r_pull_up_en(r_pull_up_en),
  .r_pull_dn_en(r_pull_dn_en),
  .t_pin_i(t_pin_i),
  .s_pin_i(s_pin_i),
  .irq_r(irq_r),
  .irq_t(irq_t),
  .irq_s(irq_s)
);

// ---- tb/ppc_top_tb.sv ----
// self-checking bench for the port pin config block
`timescale 1ns/1ps
`include "ppc_regs.vh"
module ppc_top_tb;
  logic mclk = 0;
  logic nrst = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic rd_dph = 0;
  logic lk_ph = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0;
  logic [7:0] r_dir_out = 0;
  logic [7:0] r_out_data = 0;
  logic [31:0] rnd = 32'd68275;
  logic [31:0] exp_q[$];
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire [7:0] r_pad_o, r_pad_oe_n, r_pull_up_en, r_pull_dn_en, r_pad_i, t_pin_i, s_pin_i;
  wire irq_r, irq_t, irq_s;
  int fails = 0;
  int checks_done = 0;
  initial begin
    forever #50 mclk = ~mclk;
  end
  ppc_top #(.W(8)) u_ppc_top (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .r_dir_out(r_dir_out), .r_out_data(r_out_data), .r_pad_i(r_pad_i), .r_pad_o(r_pad_o),
    .r_pad_oe_n(r_pad_oe_n), .r_pull_up_en(r_pull_up_en), .r_pull_dn_en(r_pull_dn_en), .t_pin_i(t_pin_i),
    .s_pin_i(s_pin_i), .irq_r(irq_r), .irq_t(irq_t), .irq_s(irq_s));
  ppc_pins_model u_ppc_pins_model (.mclk(mclk), .r_pad_o(r_pad_o), .r_pad_oe_n(r_pad_oe_n),
    .r_pull_up_en(r_pull_up_en), .r_pad_i(r_pad_i), .t_pin_i(t_pin_i), .s_pin_i(s_pin_i));
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (!hready) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dph <= !w;
    @(posedge mclk);
    while (!hready) @(posedge mclk);
    rd_dph <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // pads and requests settle one edge after their cause; checked mid-cycle
  task look(input logic [31:0] pe, input logic [2:0] ie);
    exp_q.push_back(pe);
    exp_q.push_back({29'h0, ie});
    @(posedge mclk);
    lk_ph <= 1'b1;
    @(posedge mclk);
    lk_ph <= 1'b0;
  endtask
  always @(posedge mclk) if (rd_dph) chk(hrdata, exp_q.pop_front());
  always @(negedge mclk) begin
    if (lk_ph) begin
      chk({r_pad_o, r_pad_oe_n, r_pull_up_en, r_pull_dn_en}, exp_q.pop_front());
      chk({29'h0, irq_r, irq_t, irq_s}, exp_q.pop_front());
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    look(32'h00ffff00, 3'b000);
    rd(`PPC_R_PE_OFS, 32'hff);
    rd(`PPC_T_IF_OFS, 32'h0);
    rd(`PPC_S_IF_OFS, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      bus(`PPC_T_IE_OFS, 1'b1, rnd);
      rd(`PPC_T_IE_OFS, {24'h0, rnd[7:0] & `PPC_T_MASK});
      bus(`PPC_S_IE_OFS, 1'b1, rnd);
      rd(`PPC_S_IE_OFS, {24'h0, rnd[7:0] & `PPC_S_MASK});
    end
    for (int a = 'h30; a <= 'h40; a += 4) begin
      bus(8'(a), 1'b1, 32'hff);
      rd(8'(a), 32'h0);
    end
    bus(`PPC_T_POL_OFS, 1'b1, 32'h60);
    bus(`PPC_T_IE_OFS, 1'b1, 32'h20);
    bus(`PPC_S_IE_OFS, 1'b1, 32'h0);
    u_ppc_pins_model.drive(2'd1, 8'h60);
    u_ppc_pins_model.drive(2'd2, 8'h00);
    repeat (6) @(posedge mclk);
    u_ppc_pins_model.drive(2'd1, 8'h00);
    repeat (6) @(posedge mclk);
    rd(`PPC_T_IF_OFS, 32'h60);
    rd(`PPC_S_IF_OFS, 32'h6c);
    rd(`PPC_PIN_OFS, 32'h1e);
    look(32'h00ffff00, 3'b010);
    bus(`PPC_T_IF_OFS, 1'b1, 32'h40);
    bus(`PPC_T_IF_OFS, 1'b1, 32'h0);
    rd(`PPC_T_IF_OFS, 32'h20);
    bus(`PPC_T_IE_OFS, 1'b1, 32'h0);
    bus(`PPC_S_IE_OFS, 1'b1, 32'h6c);
    look(32'h00ffff00, 3'b001);
    bus(`PPC_S_IF_OFS, 1'b1, 32'hff);
    look(32'h00ffff00, 3'b000);
    bus(`PPC_S_POL_OFS, 1'b1, 32'h1c);
    rd(`PPC_S_POL_OFS, 32'h0c);
    u_ppc_pins_model.drive(2'd2, 8'h6c);
    repeat (6) @(posedge mclk);
    rd(`PPC_S_IF_OFS, 32'h0c);
    look(32'h00ffff00, 3'b001);
    bus(`PPC_S_IF_OFS, 1'b1, 32'h0c);
    look(32'h00ffff00, 3'b000);
    bus(`PPC_R_POL_OFS, 1'b1, 32'h01);
    bus(`PPC_R_IE_OFS, 1'b1, 32'h01);
    u_ppc_pins_model.drive(2'd0, 8'h1d);
    repeat (6) @(posedge mclk);
    rd(`PPC_R_IF_OFS, 32'h03);
    look(32'h00fffe01, 3'b100);
    bus(`PPC_R_PE_OFS, 1'b1, 32'h0f);
    bus(`PPC_R_OD_OFS, 1'b1, 32'h0f);
    u_ppc_pins_model.drive(2'd3, 8'h00);
    look(32'h00ff0e01, 3'b100);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      r_dir_out <= rnd[15:8];
      r_out_data <= rnd[7:0];
      look({rnd[7:0] & 8'hf0, ~(rnd[15:8] & ~(rnd[7:0] & 8'h0f)), ~rnd[15:8] & 8'h0e, ~rnd[15:8] & 8'h01},
        3'b100);
    end
    @(posedge mclk);
    report_and_stop();
  end
endmodule
